/* eepg_core.sv */
// nonvolatile page store: sram image, eeprom image, commit, program and restart load
// Operation
// - host sets index high and low, then a data write stores the byte there
// - program cycle allowed only while the unlock register holds EAh
// - writing 13h then 10h to control copies sram into eeprom
// - writing 00h to the key register relocks; program cycles then refused
// - mode strap low at start-up selects soft-pin mode and strap page
// - power-down toggle restarts, re-samples straps and applies the page
// - upper two-level, lower three-level strap map to pages 0..5
// - commit page register picks which page receives the next commit
// - commit bit set from 0 to 1 copies live registers into selected page and base
// - image is 345 bytes, indices 0 to 344, eight bits each
// - base 0-38, pages at 39,90,141,192,243,288 up to 344
// - bytes 0 to 10 are read-only to image writes
// - byte 11 bits 7:3 give the upper target address bits
// - byte 12 holds the stored image revision
// - sram data register reads sram, readback register reads eeprom
// - index is high and low bytes concatenated, valid 0000h to 0158h
module eepg_core
	import eepg_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic         reg_wr,
	input  wire logic         reg_rd,
	input  wire logic [7:0]   reg_addr,
	input  wire logic [7:0]   reg_wdata,
	output logic      [7:0]   reg_rdata,
	input  wire logic         power_down_pin_n,
	input  wire logic         strap_mode_select,
	input  wire logic         page_strap_upper,
	input  wire logic [1:0]   page_strap_lower,
	output logic      [8:0]   live_index,
	input  wire logic [7:0]   live_data,
	output logic              cfg_load_valid,
	output logic      [8:0]   cfg_load_index,
	output logic      [7:0]   cfg_load_data,
	output logic              soft_pin_mode,
	output logic      [2:0]   active_page,
	output logic      [4:0]   target_addr_msb,
	output logic      [7:0]   eeprom_revision,
	output logic              busy
);

	////////////////////////////////////////////////////////////////////////////
	// storage: both images live here, no reset on the arrays
	logic [7:0] sram   [0:IMAGE_LAST];
	logic [7:0] eeprom [0:IMAGE_LAST];

	eepg_state_t state;
	eepg_state_t next_state;
	logic [8:0]  walk_idx;
	logic [7:0]  ctrl;
	logic [7:0]  index_high;
	logic [7:0]  index_low;
	logic [7:0]  key;
	logic [7:0]  commit_page;
	logic        prog_armed;
	logic [2:0]  strap_page;

	////////////////////////////////////////////////////////////////////////////
	// register decode
	wire wr_ctrl   = reg_wr && (reg_addr == OFS_NVM_CONTROL);
	wire wr_high   = reg_wr && (reg_addr == OFS_INDEX_HIGH);
	wire wr_low    = reg_wr && (reg_addr == OFS_INDEX_LOW);
	wire wr_sram   = reg_wr && (reg_addr == OFS_SRAM_DATA);
	wire wr_key    = reg_wr && ((reg_addr == OFS_UNLOCK_KEY) || (reg_addr == OFS_KEY_ALT));
	wire wr_page   = reg_wr && (reg_addr == OFS_COMMIT_PAGE);
	wire idle      = (state == ST_IDLE);
	wire restart_n = power_down_pin_n && !sys_rst;

	// index formed from both bytes; beyond the last byte nothing is touched
	wire [15:0] mem_index = {index_high, index_low};
	wire        idx_ok    = mem_index <= {7'h00, IMAGE_LAST};
	wire [8:0]  host_idx  = mem_index[8:0];
	wire        unlocked  = (key == UNLOCK_KEY);

	////////////////////////////////////////////////////////////////////////////
	// start conditions; writes during a walk are dropped to keep the copy coherent
	wire host_sram_we = wr_sram && idle && idx_ok && (host_idx > PROT_LAST);
	wire commit_start = wr_ctrl && idle && reg_wdata[COMMIT_BIT] && !ctrl[COMMIT_BIT];
	wire prog_start   = wr_ctrl && idle && unlocked && prog_armed &&
	                    (reg_wdata == PROG_GO_CMD);

	////////////////////////////////////////////////////////////////////////////
	// partition membership of the walk index
	wire       sel_ok   = commit_page < {5'h00, PAGE_COUNT};
	wire [2:0] sel_page = sel_ok ? commit_page[2:0] : 3'h0;
	wire       in_base  = walk_idx <= BASE_LAST;
	wire       in_sel   = sel_ok && (walk_idx >= PAGE_FIRST[sel_page]) &&
	                      (walk_idx <= PAGE_LAST[sel_page]);
	wire       in_act   = (walk_idx >= PAGE_FIRST[active_page]) &&
	                      (walk_idx <= PAGE_LAST[active_page]);
	wire       walk_end = (walk_idx == IMAGE_LAST);

	////////////////////////////////////////////////////////////////////////////
	// single sram write port shared by host, commit and restart load
	wire       commit_we = (state == ST_COMMIT) && (walk_idx > PROT_LAST) &&
	                       (in_base || in_sel);
	wire       load_we   = (state == ST_LOAD);
	wire       sram_we   = host_sram_we || commit_we || load_we;
	wire [8:0] sram_wadr = idle ? host_idx : walk_idx;
	wire [7:0] sram_wdat = (state == ST_LOAD)   ? eeprom[walk_idx] :
	                       (state == ST_COMMIT) ? live_data : reg_wdata;
	wire       prog_we   = (state == ST_PROG);

	////////////////////////////////////////////////////////////////////////////
	// read mux; unmapped offsets and out-of-range indices read zero
	wire [7:0] rd_mux =
		(reg_addr == OFS_NVM_CONTROL)  ? {!idle, ctrl[6:0]} :
		(reg_addr == OFS_INDEX_HIGH)   ? index_high :
		(reg_addr == OFS_INDEX_LOW)    ? index_low :
		(reg_addr == OFS_SRAM_DATA)    ? (idx_ok ? sram[host_idx] : 8'h00) :
		(reg_addr == OFS_NVM_READBACK) ? (idx_ok ? eeprom[host_idx] : 8'h00) :
		(reg_addr == OFS_UNLOCK_KEY)   ? key :
		(reg_addr == OFS_KEY_ALT)      ? key :
		(reg_addr == OFS_COMMIT_PAGE)  ? commit_page : 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// strap decode, sampled only while held in restart
	eepg_page_decode u_decode (
		.page_strap_upper (page_strap_upper),
		.page_strap_lower (page_strap_lower),
		.page             (strap_page)
	);

	////////////////////////////////////////////////////////////////////////////
	// sequencer: restart load, idle, program walk, commit walk
	always_comb begin
		next_state = state;
		unique case (state)
			ST_RESTART: if (restart_n) next_state = ST_LOAD;
			ST_LOAD:    if (walk_end) next_state = ST_IDLE;
			ST_IDLE: begin
				if (prog_start) begin
					next_state = ST_PROG;
				end else if (commit_start) begin
					next_state = ST_COMMIT;
				end
			end
			ST_PROG:    if (walk_end) next_state = ST_IDLE;
			ST_COMMIT:  if (walk_end) next_state = ST_IDLE;
		endcase
		if (!restart_n) next_state = ST_RESTART;
	end

	// state and walk counter
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state    <= ST_RESTART;
			walk_idx <= 9'h000;
		end else begin
			state    <= next_state;
			walk_idx <= (next_state != state) ? 9'h000 : 9'(walk_idx + 9'h001);
		end
	end

	// straps caught by the clock while restart holds, never by reset itself
	always_ff @(posedge clk) begin
		if (state == ST_RESTART) begin
			soft_pin_mode <= !strap_mode_select;
			active_page   <= strap_page;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// host registers; power-down clears them like a restart
	always_ff @(posedge clk) begin
		if (!restart_n) begin
			ctrl        <= CTRL_RESET;
			index_high  <= INDEX_RESET;
			index_low   <= INDEX_RESET;
			key         <= KEY_RESET;
			commit_page <= PAGE_RESET;
			prog_armed  <= 1'b0;
		end else begin
			if (wr_ctrl) ctrl <= reg_wdata;
			if (wr_high) index_high <= reg_wdata;
			if (wr_low) index_low <= reg_wdata;
			if (wr_key) key <= reg_wdata;
			if (wr_page) commit_page <= reg_wdata;
			// arming needs the key too; any other control write disarms
			if (wr_ctrl) prog_armed <= idle && unlocked && (reg_wdata == PROG_ARM_CMD);
		end
	end

	// read data held until the next read
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= rd_mux;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// image arrays
	always_ff @(posedge clk) begin
		if (sram_we) sram[sram_wadr] <= sram_wdat;
	end

	// program copies sram as it stands; the host must have filled it first
	always_ff @(posedge clk) begin
		if (prog_we) eeprom[walk_idx] <= sram[walk_idx];
	end

	////////////////////////////////////////////////////////////////////////////
	// restart load stream toward the live registers, base plus chosen page
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cfg_load_valid  <= 1'b0;
			cfg_load_index  <= 9'h000;
			cfg_load_data   <= 8'h00;
			live_index      <= 9'h000;
			target_addr_msb <= 5'h00;
			eeprom_revision <= 8'h00;
			busy            <= 1'b0;
		end else begin
			// a power-down in mid-load must not leave one stray pulse behind
			cfg_load_valid <= load_we && restart_n && soft_pin_mode && (in_base || in_act);
			cfg_load_index <= walk_idx;
			cfg_load_data  <= eeprom[walk_idx];
			live_index     <= 9'(next_state == state ? walk_idx + 9'h001 : 9'h000);
			busy           <= (next_state != ST_IDLE);
			if (load_we && walk_end) begin
				target_addr_msb <= eeprom[ADDR_BYTE][ADDR_MSB_HI:ADDR_MSB_LO];
				eeprom_revision <= eeprom[REV_BYTE];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	property p_sram_store;
		@(posedge clk) disable iff (sys_rst)
		host_sram_we |=> sram[$past(host_idx)] == $past(reg_wdata);
	endproperty
	a_sram_store: assert property (p_sram_store) else $error("sram byte not stored");

	property p_protected;
		@(posedge clk) disable iff (sys_rst)
		(host_sram_we || commit_we) |-> (sram_wadr > PROT_LAST);
	endproperty
	a_protected: assert property (p_protected) else $error("protected byte written");

	property p_prog_needs_key;
		@(posedge clk) disable iff (sys_rst)
		(state == ST_IDLE) ##1 (state == ST_PROG) |-> $past(key) == UNLOCK_KEY;
	endproperty
	a_prog_needs_key: assert property (p_prog_needs_key) else $error("program without key");

	property p_locked_refuses;
		@(posedge clk) disable iff (sys_rst)
		(idle && key == LOCK_VALUE && wr_ctrl) |=> state != ST_PROG;
	endproperty
	a_locked_refuses: assert property (p_locked_refuses) else $error("locked program ran");

	property p_prog_copy;
		@(posedge clk) disable iff (sys_rst || !power_down_pin_n)
		prog_we |=> eeprom[$past(walk_idx)] === $past(sram[walk_idx]);
	endproperty
	a_prog_copy: assert property (p_prog_copy) else $error("eeprom byte not copied");

	property p_commit_range;
		@(posedge clk) disable iff (sys_rst)
		commit_we |-> (in_base || in_sel);
	endproperty
	a_commit_range: assert property (p_commit_range) else $error("commit outside page");

	property p_strap_sample;
		@(posedge clk) disable iff (sys_rst)
		(state == ST_RESTART) ##1 (state == ST_LOAD) |-> soft_pin_mode == !$past(strap_mode_select);
	endproperty
	a_strap_sample: assert property (p_strap_sample) else $error("strap mode not sampled");

	property p_restart;
		@(posedge clk) disable iff (sys_rst)
		!power_down_pin_n |=> (state == ST_RESTART) && !cfg_load_valid;
	endproperty
	a_restart: assert property (p_restart) else $error("power-down did not restart");

	property p_page_range;
		@(posedge clk) disable iff (sys_rst)
		(state == ST_LOAD) |-> active_page < PAGE_COUNT;
	endproperty
	a_page_range: assert property (p_page_range) else $error("page out of range");

	property p_index_range;
		@(posedge clk) disable iff (sys_rst)
		(reg_rd && reg_addr == OFS_SRAM_DATA && mem_index > 16'h0158) |=> reg_rdata == 8'h00;
	endproperty
	a_index_range: assert property (p_index_range) else $error("bad index read nonzero");

	// unwritten bytes hold unknowns from the blank store, so the copy is compared exactly
	property p_load_copy;
		@(posedge clk) disable iff (sys_rst)
		load_we |=> sram[$past(walk_idx)] === $past(eeprom[walk_idx]);
	endproperty
	a_load_copy: assert property (p_load_copy) else $error("restart load not copied");

	property p_prog_begin;
		@(posedge clk) disable iff (sys_rst)
		(prog_start && restart_n) |=> busy && (state == ST_PROG);
	endproperty
	a_prog_begin: assert property (p_prog_begin) else $error("program did not begin");

	property p_commit_begin;
		@(posedge clk) disable iff (sys_rst)
		(commit_start && !prog_start && restart_n) |=> busy && (state == ST_COMMIT);
	endproperty
	a_commit_begin: assert property (p_commit_begin) else $error("commit did not begin");

	property p_commit_data;
		@(posedge clk) disable iff (sys_rst)
		commit_we |=> sram[$past(walk_idx)] == $past(live_data);
	endproperty
	a_commit_data: assert property (p_commit_data) else $error("commit byte not stored");

	property p_live_index;
		@(posedge clk) disable iff (sys_rst)
		(state == ST_COMMIT) |-> live_index == walk_idx;
	endproperty
	a_live_index: assert property (p_live_index) else $error("live index off walk");

	property p_relock;
		@(posedge clk) disable iff (sys_rst)
		(wr_key && reg_wdata == LOCK_VALUE) |=> !unlocked;
	endproperty
	a_relock: assert property (p_relock) else $error("key write did not relock");

	property p_addr_latch;
		@(posedge clk) disable iff (sys_rst)
		(load_we && walk_end) |=> target_addr_msb === $past(eeprom[ADDR_BYTE][ADDR_MSB_HI:ADDR_MSB_LO]);
	endproperty
	a_addr_latch: assert property (p_addr_latch) else $error("address bits not latched");

	property p_rev_latch;
		@(posedge clk) disable iff (sys_rst)
		(load_we && walk_end) |=> eeprom_revision === $past(eeprom[REV_BYTE]);
	endproperty
	a_rev_latch: assert property (p_rev_latch) else $error("revision not latched");

	property p_sram_read;
		@(posedge clk) disable iff (sys_rst)
		(reg_rd && reg_addr == OFS_SRAM_DATA && idx_ok) |=> reg_rdata === $past(sram[host_idx]);
	endproperty
	a_sram_read: assert property (p_sram_read) else $error("sram read data wrong");

	property p_strap_page;
		@(posedge clk) disable iff (sys_rst)
		(state == ST_RESTART) ##1 (state == ST_LOAD) |-> active_page == $past(strap_page);
	endproperty
	a_strap_page: assert property (p_strap_page) else $error("strap page not sampled");

endmodule // eepg_core

/* eepg_pkg.sv */
// constants, register map and image layout of the nonvolatile page store
package eepg_pkg;

	// register offsets on the byte register port
	localparam logic [7:0] OFS_NVM_CONTROL  = 8'h89;
	localparam logic [7:0] OFS_NVM_READBACK = 8'h8D;
	localparam logic [7:0] OFS_INDEX_HIGH   = 8'h8B;
	localparam logic [7:0] OFS_INDEX_LOW    = 8'h8C;
	localparam logic [7:0] OFS_SRAM_DATA    = 8'h8E;
	localparam logic [7:0] OFS_KEY_ALT      = 8'h90;
	localparam logic [7:0] OFS_COMMIT_PAGE  = 8'h91;
	localparam logic [7:0] OFS_UNLOCK_KEY   = 8'h92;

	// reset values
	localparam logic [7:0] CTRL_RESET  = 8'h00;
	localparam logic [7:0] INDEX_RESET = 8'h00;
	localparam logic [7:0] KEY_RESET   = 8'h00;
	localparam logic [7:0] PAGE_RESET  = 8'h00;

	// key and command values
	localparam logic [7:0] UNLOCK_KEY    = 8'hEA;
	localparam logic [7:0] LOCK_VALUE    = 8'h00;
	localparam logic [7:0] PROG_ARM_CMD  = 8'h13;
	localparam logic [7:0] PROG_GO_CMD   = 8'h10;
	localparam int         COMMIT_BIT    = 6;
	localparam int         BUSY_BIT      = 7;

	// image layout
	localparam int         IDX_W        = 9;
	localparam logic [8:0] IMAGE_LAST   = 9'h158;
	localparam logic [8:0] PROT_LAST    = 9'h00A;
	localparam logic [8:0] BASE_LAST    = 9'h026;
	localparam logic [8:0] ADDR_BYTE    = 9'h00B;
	localparam logic [8:0] REV_BYTE     = 9'h00C;
	localparam int         ADDR_MSB_HI  = 7;
	localparam int         ADDR_MSB_LO  = 3;
	localparam logic [2:0] PAGE_COUNT   = 3'h6;
	localparam logic [8:0] PAGE_FIRST [0:5] = '{9'h027, 9'h05A, 9'h08D, 9'h0C0, 9'h0F3, 9'h120};
	localparam logic [8:0] PAGE_LAST  [0:5] = '{9'h059, 9'h08C, 9'h0BF, 9'h0F2, 9'h11F, 9'h158};

	// three-level strap codes
	localparam logic [1:0] LVL_LO  = 2'h0;
	localparam logic [1:0] LVL_MID = 2'h1;
	localparam logic [1:0] LVL_HI  = 2'h2;
	localparam logic [2:0] UPPER_PAGE_BASE = 3'h3;

	typedef enum logic [2:0] {
		ST_RESTART,
		ST_LOAD,
		ST_IDLE,
		ST_PROG,
		ST_COMMIT
	} eepg_state_t;

endpackage

/* eepg_page_decode.sv */
// strap pins to soft-pin page number
module eepg_page_decode
	import eepg_pkg::*;
(
	input  wire logic       page_strap_upper,
	input  wire logic [1:0] page_strap_lower,
	output logic      [2:0] page
);

	////////////////////////////////////////////////////////////////////////////
	// lower strap gives 0..2, upper strap adds three; code 3 counts as HI
	logic [2:0] lower_val;

	assign lower_val = (page_strap_lower == LVL_LO)  ? 3'h0 :
	                   (page_strap_lower == LVL_MID) ? 3'h1 : 3'h2;
	assign page      = page_strap_upper ? 3'(lower_val + UPPER_PAGE_BASE) : lower_val;

endmodule // eepg_page_decode

/* eepg_live_regs.sv */
// live register bank model that feeds the commit walk
module eepg_live_regs
	import eepg_pkg::*;
(
	input  wire logic [8:0] live_index,
	output logic      [7:0] live_data
);
	// pattern tied to the index so a byte landing in the wrong place shows up
	assign live_data = live_index[7:0] ^ 8'hC3;
endmodule // eepg_live_regs

/* eeprom_page_programming_tb_top.sv */
// self-checking bench for the nonvolatile page store
module eeprom_page_programming_tb_top
	import eepg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk;
	logic        sys_rst;
	logic        reg_wr;
	logic        reg_rd;
	logic [7:0]  reg_addr;
	logic [7:0]  reg_wdata;
	logic [7:0]  reg_rdata;
	logic        power_down_pin_n;
	logic        strap_mode_select;
	logic        page_strap_upper;
	logic [1:0]  page_strap_lower;
	logic [8:0]  live_index;
	logic [7:0]  live_data;
	logic        cfg_load_valid;
	logic [8:0]  cfg_load_index;
	logic [7:0]  cfg_load_data;
	logic        soft_pin_mode;
	logic [2:0]  active_page;
	logic [4:0]  target_addr_msb;
	logic [7:0]  eeprom_revision;
	logic        busy;
	int          num_errors = 0;
	int          num_checks = 0;
	logic [15:0] loads = 16'h0;
	logic [7:0]  load_20 = 8'h00;
	logic [7:0]  rd;
	logic [15:0] n;

	////////////////////////////////////////////////////////////////////////////////
	eepg_core dut_u (
		.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.power_down_pin_n(power_down_pin_n), .strap_mode_select(strap_mode_select),
		.page_strap_upper(page_strap_upper), .page_strap_lower(page_strap_lower),
		.live_index(live_index), .live_data(live_data), .cfg_load_valid(cfg_load_valid),
		.cfg_load_index(cfg_load_index), .cfg_load_data(cfg_load_data),
		.soft_pin_mode(soft_pin_mode), .active_page(active_page),
		.target_addr_msb(target_addr_msb), .eeprom_revision(eeprom_revision), .busy(busy)
	);
	eepg_live_regs live_u (.live_index(live_index), .live_data(live_data));

	// free-running 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// counts restart load pulses; cumulative so no second driver is needed
	always @(posedge clk) begin
		if (cfg_load_valid === 1'b1) begin
			loads <= loads + 16'h1;
			if (cfg_load_index === 9'h020)
				load_20 <= cfg_load_data;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one register write, strobe dropped at the edge that takes it
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// one register read, data sampled once the taking edge has landed
	task automatic rdr(input logic [7:0] a);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 rd = reg_rdata;
	endtask

	// index does not auto-increment, so both bytes go every time
	task automatic idx(input logic [8:0] i);
		wr(OFS_INDEX_HIGH, {7'h0, i[8]});
		wr(OFS_INDEX_LOW, i[7:0]);
	endtask

	// counts busy cycles from the taking edge on, since busy rises right after it;
	// bounded so a stuck walk cannot hang the run
	task automatic run(input int lim);
		n = 16'h0;
		for (int k = 0; k < lim; k++) begin
			#1;
			if (busy === 1'b1)
				n++;
			else if (n != 16'h0)
				break;
			@(posedge clk);
		end
	endtask

	// power-down pulse with new straps, then count the load pulses
	task automatic restart(input logic m, input logic u, input logic [1:0] l);
		logic [15:0] b;
		@(posedge clk);
		power_down_pin_n  <= 1'b0;
		strap_mode_select <= m;
		page_strap_upper  <= u;
		page_strap_lower  <= l;
		repeat (3) @(posedge clk);
		power_down_pin_n <= 1'b1;
		b = loads;
		run(1000);
		repeat (3) @(posedge clk);
		#1 n = loads - b;
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		sys_rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		power_down_pin_n = 1'b1;
		strap_mode_select = 1'b1;
		page_strap_upper = 1'b0;
		page_strap_lower = 2'h0;
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		run(1000);
		chk("load walk", 16'd345, n);
		$display("test reset done");
		// image writes finish before any program cycle
		idx(9'h020);
		wr(OFS_SRAM_DATA, 8'h5A);
		rdr(OFS_SRAM_DATA);
		chk("sram 020", 16'h5A, {8'h0, rd});
		idx(ADDR_BYTE);
		wr(OFS_SRAM_DATA, 8'hA8);
		idx(REV_BYTE);
		wr(OFS_SRAM_DATA, 8'h07);
		idx(IMAGE_LAST);
		wr(OFS_SRAM_DATA, 8'hC5);
		rdr(OFS_SRAM_DATA);
		chk("sram last", 16'hC5, {8'h0, rd});
		idx(PROT_LAST);
		wr(OFS_SRAM_DATA, 8'h77);
		rdr(OFS_SRAM_DATA);
		chk("protected", 16'h1, {15'h0, rd !== 8'h77});
		idx(9'h159);
		rdr(OFS_SRAM_DATA);
		chk("past end", 16'h0, {8'h0, rd});
		rdr(8'h00);
		chk("unmapped", 16'h0, {8'h0, rd});
		$display("test sram done");
		// program refused while locked, and without the arm step
		wr(OFS_NVM_CONTROL, PROG_ARM_CMD);
		wr(OFS_NVM_CONTROL, PROG_GO_CMD);
		run(20);
		chk("locked prog", 16'h0, n);
		wr(OFS_UNLOCK_KEY, UNLOCK_KEY);
		wr(OFS_NVM_CONTROL, PROG_GO_CMD);
		run(20);
		chk("go alone", 16'h0, n);
		wr(OFS_NVM_CONTROL, PROG_ARM_CMD);
		wr(OFS_NVM_CONTROL, PROG_GO_CMD);
		run(1000);
		chk("prog walk", 16'd345, n);
		idx(9'h020);
		rdr(OFS_NVM_READBACK);
		chk("eeprom 020", 16'h5A, {8'h0, rd});
		idx(IMAGE_LAST);
		rdr(OFS_NVM_READBACK);
		chk("eeprom last", 16'hC5, {8'h0, rd});
		wr(OFS_KEY_ALT, LOCK_VALUE);
		wr(OFS_NVM_CONTROL, PROG_ARM_CMD);
		wr(OFS_NVM_CONTROL, PROG_GO_CMD);
		run(20);
		chk("relocked", 16'h0, n);
		$display("test program done");
		// every strap combination, soft-pin mode
		for (int p = 0; p < 6; p++) begin
			restart(1'b0, p > 2, 2'(p % 3));
			chk("page", 16'(p), {13'h0, active_page});
			chk("soft mode", 16'h1, {15'h0, soft_pin_mode});
			chk("loads", 16'(BASE_LAST) + 16'(PAGE_LAST[p]) - 16'(PAGE_FIRST[p]) + 16'h2, n);
		end
		chk("load data", 16'h5A, {8'h0, load_20});
		chk("addr msb", 16'h15, {11'h0, target_addr_msb});
		chk("revision", 16'h07, {8'h0, eeprom_revision});
		restart(1'b1, 1'b0, 2'h0);
		chk("hw mode", 16'h0, {15'h0, soft_pin_mode});
		chk("hw loads", 16'h0, n);
		$display("test restart done");
		// commit into page 2 must leave page 1 alone
		idx(PAGE_FIRST[1]);
		wr(OFS_SRAM_DATA, 8'h3C);
		wr(OFS_COMMIT_PAGE, 8'h02);
		wr(OFS_NVM_CONTROL, 8'h40);
		run(1000);
		chk("commit walk", 16'd345, n);
		wr(OFS_NVM_CONTROL, 8'h00);
		idx(PAGE_FIRST[2]);
		rdr(OFS_SRAM_DATA);
		chk("page 2", {8'h0, PAGE_FIRST[2][7:0] ^ 8'hC3}, {8'h0, rd});
		idx(9'h020);
		rdr(OFS_SRAM_DATA);
		chk("base", 16'h00E3, {8'h0, rd});
		idx(PAGE_FIRST[1]);
		rdr(OFS_SRAM_DATA);
		chk("page 1", 16'h3C, {8'h0, rd});
		$display("test commit done");
		results();
	end

	// cuts a hang well past the expected few thousand cycles
	initial begin
		#200000;
		num_errors++;
		results();
	end
endmodule // eeprom_page_programming_tb_top
